//--- rtl/mne_params.svh
`ifndef MNE_PARAMS_SVH
`define MNE_PARAMS_SVH

// opcode patterns in the upper instruction byte
`define MNE_OPC_MULLIT 8'h0D
`define MNE_OPC_MULREG 7'h01
`define MNE_OPC_NEG 7'h36

// instruction word fields
`define MNE_OPC_HI 15
`define MNE_OPC_LO 8
`define MNE_OPC7_LO 9
`define MNE_ACC_BIT 8
`define MNE_FADR_HI 7

// access bank mapping: low half to bank 0, high half to the top bank
`define MNE_ACC_LO_BANK 4'h0
`define MNE_ACC_HI_BANK 4'hF

// software register indices
`define MNE_REG_WORK 3'h0
`define MNE_REG_BANK 3'h1
`define MNE_REG_PROD_LO 3'h2
`define MNE_REG_PROD_HI 3'h3
`define MNE_REG_STATUS 3'h4

// status bit positions
`define MNE_ST_C 0
`define MNE_ST_HALF 1
`define MNE_ST_Z 2
`define MNE_ST_RANGE 3
`define MNE_ST_N 4

// reset and constant values
`define MNE_RST_BYTE 8'h00
`define MNE_RST_BANK 4'h0
`define MNE_RST_STATUS 5'h00
`define MNE_RST_PROD 16'h0000
`define MNE_RST_ADDR 12'h000
`define MNE_RST_WORD 16'h0000
`define MNE_NEG_MIN 8'h80
`define MNE_ONE 8'h01

`endif

//--- rtl/mne_pkg.sv
`include "mne_params.svh"

package mne_pkg;

	// instruction cycle phases, gray on each step from IDLE through Q1, Q2 and Q3 to Q4
	typedef enum logic [2:0] {
		MNE_PH_IDLE = 3'h0,
		MNE_PH_Q1 = 3'h1,
		MNE_PH_Q2 = 3'h3,
		MNE_PH_Q3 = 3'h2,
		MNE_PH_Q4 = 3'h6
	} mne_phase_e;

	typedef enum logic [1:0] {
		MNE_OP_NONE = 2'h0,
		MNE_OP_MULLIT = 2'h1,
		MNE_OP_MULREG = 2'h2,
		MNE_OP_NEG = 2'h3
	} mne_op_e;

	typedef logic [7:0] mne_byte_t;
	typedef logic [11:0] mne_addr_t;

	typedef struct packed {
		mne_phase_e phase;
		mne_op_e op;
		logic [15:0] word;
		mne_addr_t addr;
		logic [15:0] result;
		mne_byte_t work;
		logic [3:0] bank;
		mne_byte_t prod_lo;
		mne_byte_t prod_hi;
		logic [4:0] status;
		mne_byte_t rdata;
		logic done;
	} mne_state_s;

endpackage

//--- rtl/mne_exec.sv
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "mne_params.svh"

module mne_exec (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// instruction decoder
	input wire logic INSTR_VALID,
	input wire logic [15:0] INSTR_WORD,
	output logic INSTR_READY,
	output logic INSTR_DONE,
	// data register file
	output logic [11:0] RF_ADDR,
	output logic RF_RD,
	input wire logic [7:0] RF_RDATA,
	output logic RF_WR,
	output logic [7:0] RF_WDATA,
	// software register port
	input wire logic [2:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// core state
	output logic [7:0] WORK_REG,
	output logic [4:0] STATUS_FLAGS
);
	import mne_pkg::*;

	mne_state_s s;
	mne_state_s next_s;
	mne_byte_t f_adr;
	mne_byte_t neg_val;
	logic [15:0] product;
	mne_byte_t mul_opnd;

	assign f_adr = s.word[`MNE_FADR_HI:0];
	assign neg_val = 8'(~RF_RDATA + `MNE_ONE);
	assign mul_opnd = (s.op == MNE_OP_MULLIT) ? f_adr : RF_RDATA;
	assign product = {8'h00, s.work} * {8'h00, mul_opnd};

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.rdata = `MNE_RST_BYTE;
		// software register access; the core's own write wins below
		if (REG_WR) begin
			case (REG_ADDR)
				`MNE_REG_WORK: next_s.work = REG_WDATA;
				`MNE_REG_BANK: next_s.bank = REG_WDATA[3:0];
				`MNE_REG_PROD_LO: next_s.prod_lo = REG_WDATA;
				`MNE_REG_PROD_HI: next_s.prod_hi = REG_WDATA;
				`MNE_REG_STATUS: next_s.status = REG_WDATA[4:0];
				default: next_s.work = s.work;
			endcase
		end
		if (REG_RD) begin
			case (REG_ADDR)
				`MNE_REG_WORK: next_s.rdata = s.work;
				`MNE_REG_BANK: next_s.rdata = {4'h0, s.bank};
				`MNE_REG_PROD_LO: next_s.rdata = s.prod_lo;
				`MNE_REG_PROD_HI: next_s.rdata = s.prod_hi;
				`MNE_REG_STATUS: next_s.rdata = {3'h0, s.status};
				default: next_s.rdata = `MNE_RST_BYTE;
			endcase
		end
		// four phase sequence
		case (s.phase)
			MNE_PH_Q1: begin
				next_s.phase = MNE_PH_Q2;
				if (s.word[`MNE_OPC_HI:`MNE_OPC_LO] == `MNE_OPC_MULLIT) begin
					next_s.op = MNE_OP_MULLIT;
				end else if (s.word[`MNE_OPC_HI:`MNE_OPC7_LO] == `MNE_OPC_MULREG) begin
					next_s.op = MNE_OP_MULREG;
				end else if (s.word[`MNE_OPC_HI:`MNE_OPC7_LO] == `MNE_OPC_NEG) begin
					next_s.op = MNE_OP_NEG;
				end else begin
					next_s.op = MNE_OP_NONE;
				end
				if (s.word[`MNE_ACC_BIT]) begin
					next_s.addr = {s.bank, f_adr};
				end else begin
					next_s.addr = {f_adr[7] ? `MNE_ACC_HI_BANK : `MNE_ACC_LO_BANK, f_adr};
				end
			end
			MNE_PH_Q2: next_s.phase = MNE_PH_Q3;
			MNE_PH_Q3: begin
				next_s.phase = MNE_PH_Q4;
				if (s.op == MNE_OP_NEG) begin
					next_s.result = {8'h00, neg_val};
				end else begin
					next_s.result = product;
				end
			end
			MNE_PH_Q4: begin
				next_s.phase = MNE_PH_IDLE;
				next_s.done = 1'b1;
				if (s.op == MNE_OP_MULLIT || s.op == MNE_OP_MULREG) begin
					next_s.prod_hi = s.result[15:8];
					next_s.prod_lo = s.result[7:0];
				end
				if (s.op == MNE_OP_NEG) begin
					// flags of zero minus operand
					next_s.status[`MNE_ST_N] = s.result[7];
					next_s.status[`MNE_ST_Z] = (s.result[7:0] == `MNE_RST_BYTE);
					next_s.status[`MNE_ST_C] = (s.result[7:0] == `MNE_RST_BYTE);
					next_s.status[`MNE_ST_HALF] = (s.result[3:0] == 4'h0);
					next_s.status[`MNE_ST_RANGE] = (s.result[7:0] == `MNE_NEG_MIN);
				end
			end
			default: next_s.phase = MNE_PH_IDLE;
		endcase
		// a new instruction may follow directly after the write phase
		if (INSTR_VALID && INSTR_READY) begin
			next_s.phase = MNE_PH_Q1;
			next_s.word = INSTR_WORD;
			next_s.op = MNE_OP_NONE;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			s.phase <= MNE_PH_IDLE;
			s.op <= MNE_OP_NONE;
			s.word <= `MNE_RST_WORD;
			s.addr <= `MNE_RST_ADDR;
			s.result <= `MNE_RST_PROD;
			s.work <= `MNE_RST_BYTE;
			s.bank <= `MNE_RST_BANK;
			s.prod_lo <= `MNE_RST_BYTE;
			s.prod_hi <= `MNE_RST_BYTE;
			s.status <= `MNE_RST_STATUS;
			s.rdata <= `MNE_RST_BYTE;
			s.done <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign INSTR_READY = (s.phase == MNE_PH_IDLE) || (s.phase == MNE_PH_Q4);
	assign INSTR_DONE = s.done;
	assign RF_ADDR = s.addr;
	assign RF_RD = (s.phase == MNE_PH_Q2) && (s.op == MNE_OP_MULREG || s.op == MNE_OP_NEG);
	assign RF_WR = (s.phase == MNE_PH_Q4) && (s.op == MNE_OP_NEG);
	assign RF_WDATA = s.result[7:0];
	assign REG_RDATA = s.rdata;
	assign WORK_REG = s.work;
	assign STATUS_FLAGS = s.status;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	sequence seq_read_phase(mne_op_e o);
		(s.phase == MNE_PH_Q2) && (s.op == o) && RF_RD;
	endsequence

	sequence seq_write_phase;
		(s.phase == MNE_PH_Q4) && INSTR_DONE == 1'b0;
	endsequence

	sequence seq_decode_mullit;
		(s.phase == MNE_PH_Q1) && (s.word[`MNE_OPC_HI:`MNE_OPC_LO] == `MNE_OPC_MULLIT);
	endsequence

	sequence seq_decode_mulreg;
		(s.phase == MNE_PH_Q1) && (s.word[`MNE_OPC_HI:`MNE_OPC7_LO] == `MNE_OPC_MULREG);
	endsequence

	sequence seq_decode_neg;
		(s.phase == MNE_PH_Q1) && (s.word[`MNE_OPC_HI:`MNE_OPC7_LO] == `MNE_OPC_NEG);
	endsequence

	AST_MUL_LIT: assert property (
		((s.phase == MNE_PH_Q3) && (s.op == MNE_OP_MULLIT) && !REG_WR)
		|-> ##2 ({s.prod_hi, s.prod_lo}
		== ({8'h00, $past(s.work, 2)} * {8'h00, $past(f_adr, 2)})))
		else $error("literal product wrong");

	AST_MUL_REG: assert property (
		seq_read_phase(MNE_OP_MULREG) ##1 !REG_WR
		|-> ##2 ({s.prod_hi, s.prod_lo}
		== ({8'h00, $past(s.work, 2)} * {8'h00, $past(RF_RDATA, 2)})))
		else $error("register product wrong");

	AST_PROD_SPLIT: assert property (
		((s.phase == MNE_PH_Q4) && (s.op != MNE_OP_NEG) && (s.op != MNE_OP_NONE) && !REG_WR)
		|=> (s.prod_hi == $past(s.result[15:8])) && (s.prod_lo == $past(s.result[7:0])))
		else $error("product halves misplaced");

	AST_MUL_KEEP: assert property (
		((s.phase == MNE_PH_Q1) && !RF_WR) ##1 ((s.op == MNE_OP_MULLIT || s.op == MNE_OP_MULREG)
		&& !REG_WR) [*3] |-> !RF_WR && $stable(s.work))
		else $error("multiply disturbed an operand");

	AST_MUL_FLAGS: assert property (
		((s.phase == MNE_PH_Q4) && (s.op == MNE_OP_MULLIT || s.op == MNE_OP_MULREG) && !REG_WR)
		|=> $stable(s.status))
		else $error("multiply changed flags");

	AST_BANK_SEL: assert property (
		(s.phase == MNE_PH_Q2) |-> (RF_ADDR[7:0] == f_adr) && (s.word[`MNE_ACC_BIT]
		? (RF_ADDR[11:8] == $past(s.bank))
		: (RF_ADDR[11:8] == (f_adr[7] ? `MNE_ACC_HI_BANK : `MNE_ACC_LO_BANK))))
		else $error("bank routing wrong");

	AST_NEG_WB: assert property (
		seq_read_phase(MNE_OP_NEG) ##1 1'b1 |=> RF_WR && (RF_ADDR == $past(RF_ADDR, 2))
		&& (RF_WDATA == 8'(~$past(RF_RDATA) + `MNE_ONE)))
		else $error("negate write back wrong");

	AST_NEG_FLAGS: assert property (
		(seq_write_phase ##0 ((s.op == MNE_OP_NEG) && !REG_WR)) |=>
		(s.status[`MNE_ST_Z] == ($past(RF_WDATA) == `MNE_RST_BYTE))
		&& (s.status[`MNE_ST_N] == $past(RF_WDATA[7])))
		else $error("negate zero or sign flag wrong");

	AST_NEG_CV: assert property (
		(seq_write_phase ##0 ((s.op == MNE_OP_NEG) && !REG_WR)) |=>
		(s.status[`MNE_ST_C] == ($past(RF_WDATA) == `MNE_RST_BYTE))
		&& (s.status[`MNE_ST_RANGE] == ($past(RF_WDATA) == `MNE_NEG_MIN)))
		else $error("negate carry or overflow wrong");

	AST_ONE_CYCLE: assert property (
		(INSTR_VALID && INSTR_READY) |=> (s.phase == MNE_PH_Q1) ##1 (s.phase == MNE_PH_Q2)
		##1 (s.phase == MNE_PH_Q3) ##1 ((s.phase == MNE_PH_Q4) && !INSTR_DONE) ##1 INSTR_DONE)
		else $error("instruction phases out of order");

	AST_NEG_STEPS: assert property (
		seq_decode_neg
		|=> RF_RD ##1 !RF_RD ##1 (RF_WR && !RF_RD) ##1 !RF_WR)
		else $error("negate read and write out of step");

	AST_MULREG_STEPS: assert property (
		seq_decode_mulreg
		|=> RF_RD ##1 !RF_RD ##1 !RF_WR)
		else $error("register multiply access out of step");

	AST_MULLIT_STEPS: assert property (
		seq_decode_mullit
		|=> !RF_RD ##1 !RF_RD ##1 !RF_WR)
		else $error("literal multiply touched the file");

	AST_READY_BUSY: assert property (
		((s.phase == MNE_PH_Q1) || (s.phase == MNE_PH_Q2) || (s.phase == MNE_PH_Q3))
		|-> !INSTR_READY)
		else $error("ready while busy");

	AST_DONE_PULSE: assert property (
		INSTR_DONE
		|=> !INSTR_DONE)
		else $error("done longer than one cycle");

	AST_MUL_NO_WRITE: assert property (
		((s.op == MNE_OP_MULLIT) || (s.op == MNE_OP_MULREG))
		|-> !RF_WR)
		else $error("multiply wrote the file");

	AST_ADDR_HOLD: assert property (
		((s.phase == MNE_PH_Q3) || (s.phase == MNE_PH_Q4))
		|-> $stable(RF_ADDR))
		else $error("file address moved inside instruction");

	AST_NEG_HALF: assert property (
		seq_read_phase(MNE_OP_NEG) ##2 1'b1
		|=> (s.status[`MNE_ST_HALF] == ($past(RF_RDATA[3:0], 2) == 4'h0)))
		else $error("negate half carry wrong");

	AST_NONE_QUIET: assert property (
		((s.phase == MNE_PH_Q4) && (s.op == MNE_OP_NONE) && !REG_WR)
		|-> !RF_WR ##1 $stable({s.prod_hi, s.prod_lo, s.status}))
		else $error("unknown opcode had an effect");

	AST_PROD_READ: assert property (
		(REG_RD && (REG_ADDR == `MNE_REG_PROD_HI))
		|=> (REG_RDATA == $past(s.prod_hi)))
		else $error("product high readback wrong");

	AST_WORK_READ: assert property (
		(REG_RD && (REG_ADDR == `MNE_REG_WORK))
		|=> (REG_RDATA == $past(s.work)))
		else $error("working register readback wrong");

	AST_BANK_READ: assert property (
		(REG_RD && (REG_ADDR == `MNE_REG_BANK))
		|=> (REG_RDATA == {4'h0, $past(s.bank)}))
		else $error("bank readback wrong");

	AST_STATUS_READ: assert property (
		(REG_RD && (REG_ADDR == `MNE_REG_STATUS))
		|=> (REG_RDATA == {3'h0, $past(s.status)}))
		else $error("status readback wrong");

endmodule
`default_nettype wire

//--- sim/mne_rf_model.sv
`timescale 1ns/10ps
`default_nettype none

module mne_rf_model (
	// clock
	input wire logic clk,
	// register file port
	input wire logic [11:0] addr,
	input wire logic rd,
	input wire logic wr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:4095];

	// read data held one cycle, then scrambled
	always @(posedge clk) begin
		if (rd) begin
			rdata <= mem[addr];
		end else begin
			rdata <= ~rdata;
		end
		if (wr) begin
			mem[addr] <= wdata;
		end
	end
endmodule

`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic clk, rst, valid, rd, wr, reg_wr, reg_rd, ready, done;
	logic [15:0] word;
	logic [11:0] addr;
	logic [7:0] rrd, wd, rwd, rdo, work;
	logic [2:0] radr;
	logic [4:0] flags;
	int mismatches, num_checks;

	mne_exec i_dut (.CLK_SYS(clk), .RST(rst), .INSTR_VALID(valid), .INSTR_WORD(word),
		.INSTR_READY(ready), .INSTR_DONE(done), .RF_ADDR(addr), .RF_RD(rd), .RF_RDATA(rrd),
		.RF_WR(wr), .RF_WDATA(wd), .REG_ADDR(radr), .REG_WDATA(rwd), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_RDATA(rdo), .WORK_REG(work), .STATUS_FLAGS(flags));
	mne_rf_model i_rf (.clk(clk), .addr(addr), .rd(rd), .wr(wr), .wdata(wd), .rdata(rrd));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		radr <= a;
		rwd <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_check(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		radr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(16'(rdo), 16'(e));
	endtask

	// one instruction, bounded wait for done
	task automatic run(input logic [15:0] w);
		int n;
		@(posedge clk);
		valid <= 1'b1;
		word <= w;
		#1;
		chk(16'(ready), 16'h0001);
		@(posedge clk);
		valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
			if (n == 1) begin
				chk(16'(ready), 16'h0000);
			end
		end while (done !== 1'b1 && n < 10);
		if (done !== 1'b1) begin
			mismatches++;
			wrap_up();
		end else begin
			chk(16'(n), 16'h0004);
		end
	endtask

	task automatic t_mullit();
		reg_write(3'h0, 8'hE2);
		reg_write(3'h4, 8'h1F);
		run(16'h0DC4);
		reg_check(3'h3, 8'hAD);
		reg_check(3'h2, 8'h08);
		chk(16'(work), 16'h00E2);
		chk(16'(flags), 16'h001F);
		reg_write(3'h4, 8'h00);
		run(16'h0D00);
		chk(16'(flags), 16'h0000);
		reg_check(3'h3, 8'h00);
		reg_write(3'h0, 8'hFF);
		run(16'h0DFF);
		reg_check(3'h3, 8'hFE);
		reg_check(3'h2, 8'h01);
	endtask

	task automatic t_mulreg();
		i_rf.mem[12'h010] = 8'hB5;
		i_rf.mem[12'h590] = 8'h07;
		i_rf.mem[12'hF90] = 8'h33;
		reg_write(3'h0, 8'hC4);
		reg_write(3'h1, 8'h05);
		reg_write(3'h4, 8'h15);
		run(16'h0210);
		reg_check(3'h3, 8'h8A);
		reg_check(3'h2, 8'h94);
		chk(16'(work), 16'h00C4);
		chk(16'(i_rf.mem[12'h010]), 16'h00B5);
		run(16'h0390);
		reg_check(3'h3, 8'h05);
		reg_check(3'h2, 8'h5C);
		run(16'h0290);
		reg_check(3'h3, 8'h27);
		reg_check(3'h2, 8'h0C);
		chk(16'(flags), 16'h0015);
		reg_check(3'h0, 8'hC4);
		reg_check(3'h1, 8'h05);
		reg_check(3'h4, 8'h15);
		run(16'hFFFF);
		reg_check(3'h3, 8'h27);
		reg_check(3'h2, 8'h0C);
		chk(16'(flags), 16'h0015);
	endtask

	task automatic t_neg();
		logic [7:0] ops [5] = '{8'h3A, 8'h00, 8'h80, 8'h01, 8'hFF};
		logic [7:0] op, res, f;
		logic [11:0] a;
		for (int i = 0; i < 5; i++) begin
			op = ops[i];
			res = ~op + 8'h01;
			f = 8'h20 + 8'(i);
			a = {(i % 2 == 1) ? 4'h5 : 4'h0, f};
			i_rf.mem[a] = op;
			run({7'h36, 1'(i % 2), f});
			chk(16'(i_rf.mem[a]), 16'(res));
			chk(16'(flags), 16'({res[7], op == 8'h80, res == 8'h00,
				op[3:0] == 4'h0, op == 8'h00}));
		end
	endtask

	initial begin
		rst = 1'b1;
		valid = 1'b0;
		word = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		radr = 3'h0;
		rwd = 8'h00;
		mismatches = 0;
		num_checks = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_mullit();
		t_mulreg();
		t_neg();
		wrap_up();
	end
endmodule

`default_nettype wire
